// >>> cmp_regs_pkg.sv
// package: offsets, field layout and reset values of the comparator config registers
package cmp_regs_pkg;
  localparam logic [7:0] CMP0_INPUT_SELECT_ADDR = 8'h9C;
  localparam logic [7:0] CMP1_CONTROL_ADDR = 8'h9D;
  localparam logic [7:0] CMP1_MODE_SELECT_ADDR = 8'h9E;
  localparam logic [7:0] CMP1_INPUT_SELECT_ADDR = 8'h9F;
  localparam int MODE_LSB = 0;
  localparam int FALL_IE_BIT = 4;
  localparam int RISE_IE_BIT = 5;
  localparam int FALL_FLAG_BIT = 4;
  localparam int RISE_FLAG_BIT = 5;
  localparam int OUT_STATE_BIT = 6;
  localparam int POS_LSB = 0;
  localparam int NEG_LSB = 4;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h33;
  localparam logic [1:0] MODE_RESET = 2'h2;
  localparam logic [3:0] SEL_RESET = 4'h7;
  localparam logic [3:0] SEL_LAST_PIN = 4'hB;
  localparam int PINS_PER_SIDE = 12;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [3:0] neg_sel;
    logic [3:0] pos_sel;
  } mux_sel_t;
endpackage : cmp_regs_pkg

// >>> cmp_input_mux.sv
// one comparator input multiplexer: select code to one-hot pin connect
`timescale 1ns/1ps
module cmp_input_mux (
  input wire logic [3:0] sel_i, // select code
  output logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] pin_en_o // one-hot pin connect
);
  import cmp_regs_pkg::*;
  always_comb begin
    pin_en_o = '0;
    // codes above the last pin connect nothing
    if (sel_i <= SEL_LAST_PIN) begin
      pin_en_o[sel_i] = 1'b1;
    end
  end
endmodule : cmp_input_mux

// >>> comparator_config_regs.sv
// comparator mux select, comparator1 mode, edge flags and interrupt request
`timescale 1ns/1ps
module comparator_config_regs (
  input wire logic mclk_i, // system clock, 40 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic clk_en_i, // freezes all state when low
  input wire cmp_regs_pkg::sfr_req_t sfr_req_i, // register access request
  output logic [7:0] sfr_rdata_o, // read data, one cycle after rd
  input wire logic cmp1_raw_i, // analog comparator1 output, asynchronous
  output cmp_regs_pkg::mux_sel_t cmp0_sel_o, // cmp0 selects
  output cmp_regs_pkg::mux_sel_t cmp1_sel_o, // cmp1 selects
  output logic [1:0] cmp1_response_mode_o, // cmp1 speed/power mode
  output logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp0_pos_pin_o, // cmp0 + pin connect
  output logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp0_neg_pin_o, // cmp0 - pin connect
  output logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp1_pos_pin_o, // cmp1 + pin connect
  output logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp1_neg_pin_o, // cmp1 - pin connect
  output logic cmp1_irq_o // cmp1 interrupt request, level
);
  import cmp_regs_pkg::*;

  mux_sel_t cmp0_sel_ff;
  mux_sel_t cmp1_sel_ff;
  logic [1:0] cmp1_response_mode_ff;
  logic cmp1_rise_irq_en_ff;
  logic cmp1_fall_irq_en_ff;
  logic cmp1_rise_flag_ff;
  logic cmp1_fall_flag_ff;
  logic sync1_ff;
  logic cmp1_out_state_ff;
  logic out_prev_ff;
  logic [PINS_PER_SIDE-1:0] p0_pos;
  logic [PINS_PER_SIDE-1:0] p0_neg;
  logic [PINS_PER_SIDE-1:0] p1_pos;
  logic [PINS_PER_SIDE-1:0] p1_neg;
  logic [PINS_PER_SIDE-1:0] p0_pos_ff;
  logic [PINS_PER_SIDE-1:0] p0_neg_ff;
  logic [PINS_PER_SIDE-1:0] p1_pos_ff;
  logic [PINS_PER_SIDE-1:0] p1_neg_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic [7:0] rd_mux;
  logic nxt_rise;
  logic nxt_fall;
  logic rise_evt;
  logic fall_evt;
  logic wr_ctl;
  logic wr_mode;
  logic wr_sel0;
  logic wr_sel1;

  assign wr_ctl = sfr_req_i.wr && sfr_req_i.addr == CMP1_CONTROL_ADDR;
  assign wr_mode = sfr_req_i.wr && sfr_req_i.addr == CMP1_MODE_SELECT_ADDR;
  assign wr_sel0 = sfr_req_i.wr && sfr_req_i.addr == CMP0_INPUT_SELECT_ADDR;
  assign wr_sel1 = sfr_req_i.wr && sfr_req_i.addr == CMP1_INPUT_SELECT_ADDR;

  // input select registers, one per comparator, fully independent
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp0_sel_ff <= '{neg_sel: SEL_RESET, pos_sel: SEL_RESET};
    end else if (clk_en_i && wr_sel0) begin
      cmp0_sel_ff <= mux_sel_t'(sfr_req_i.wdata);
    end
  end

  // same layout and encoding as cmp0, but storage of its own
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp1_sel_ff <= '{neg_sel: SEL_RESET, pos_sel: SEL_RESET};
    end else if (clk_en_i && wr_sel1) begin
      cmp1_sel_ff <= mux_sel_t'(sfr_req_i.wdata);
    end
  end

  // mode register: unused bits never stored
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp1_response_mode_ff <= MODE_RESET;
      cmp1_rise_irq_en_ff <= 1'b0;
      cmp1_fall_irq_en_ff <= 1'b0;
    end else if (clk_en_i && wr_mode) begin
      cmp1_response_mode_ff <= sfr_req_i.wdata[MODE_LSB+:2];
      cmp1_rise_irq_en_ff <= sfr_req_i.wdata[RISE_IE_BIT];
      cmp1_fall_irq_en_ff <= sfr_req_i.wdata[FALL_IE_BIT];
    end
  end

  // comparator output crosses from the analog side; only the second flop is read
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= 1'b0;
      cmp1_out_state_ff <= 1'b0;
      out_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      sync1_ff <= cmp1_raw_i;
      cmp1_out_state_ff <= sync1_ff;
      out_prev_ff <= cmp1_out_state_ff;
    end
  end

  // edges taken on the settled state, costs one edge of latency
  assign rise_evt = cmp1_out_state_ff && !out_prev_ff;
  assign fall_evt = !cmp1_out_state_ff && out_prev_ff;

  // edge flags: a new edge wins over a software clear in the same cycle
  always_comb begin
    nxt_rise = cmp1_rise_flag_ff;
    nxt_fall = cmp1_fall_flag_ff;
    if (wr_ctl) begin
      nxt_rise = sfr_req_i.wdata[RISE_FLAG_BIT];
      nxt_fall = sfr_req_i.wdata[FALL_FLAG_BIT];
    end
    if (rise_evt) begin
      nxt_rise = 1'b1;
    end
    if (fall_evt) begin
      nxt_fall = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp1_rise_flag_ff <= 1'b0;
    end else if (clk_en_i) begin
      cmp1_rise_flag_ff <= nxt_rise;
    end
  end

  // falling flag kept apart, so each flag clears on its own write bit
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp1_fall_flag_ff <= 1'b0;
    end else if (clk_en_i) begin
      cmp1_fall_flag_ff <= nxt_fall;
    end
  end

  // built from next flag values so irq follows a set or clear at the same edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ff <= 1'b0;
    end else if (clk_en_i) begin
      irq_ff <= (nxt_rise && cmp1_rise_irq_en_ff) || (nxt_fall && cmp1_fall_irq_en_ff);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (sfr_req_i.addr)
      CMP0_INPUT_SELECT_ADDR: rd_mux = cmp0_sel_ff;
      CMP1_INPUT_SELECT_ADDR: rd_mux = cmp1_sel_ff;
      CMP1_MODE_SELECT_ADDR: rd_mux = {2'h0, cmp1_rise_irq_en_ff, cmp1_fall_irq_en_ff,
                                       2'h0, cmp1_response_mode_ff} & MODE_WRITE_MASK;
      CMP1_CONTROL_ADDR: rd_mux = {1'b0, cmp1_out_state_ff, cmp1_rise_flag_ff,
                                   cmp1_fall_flag_ff, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data registered, held until the next taken read
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 8'h00;
    end else if (clk_en_i && sfr_req_i.rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // four independent decoders, so both muxes may pick the same pin
  cmp_input_mux u_p0 (.sel_i(cmp0_sel_ff.pos_sel), .pin_en_o(p0_pos));
  cmp_input_mux u_n0 (.sel_i(cmp0_sel_ff.neg_sel), .pin_en_o(p0_neg));
  cmp_input_mux u_p1 (.sel_i(cmp1_sel_ff.pos_sel), .pin_en_o(p1_pos));
  cmp_input_mux u_n1 (.sel_i(cmp1_sel_ff.neg_sel), .pin_en_o(p1_neg));

  // pin connects registered so outputs come from flops; one-cycle lag after write
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      p0_pos_ff <= '0;
      p0_neg_ff <= '0;
    end else if (clk_en_i) begin
      p0_pos_ff <= p0_pos;
      p0_neg_ff <= p0_neg;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      p1_pos_ff <= '0;
      p1_neg_ff <= '0;
    end else if (clk_en_i) begin
      p1_pos_ff <= p1_pos;
      p1_neg_ff <= p1_neg;
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign cmp0_sel_o = cmp0_sel_ff;
  assign cmp1_sel_o = cmp1_sel_ff;
  assign cmp1_response_mode_o = cmp1_response_mode_ff;
  assign cmp0_pos_pin_o = p0_pos_ff;
  assign cmp0_neg_pin_o = p0_neg_ff;
  assign cmp1_pos_pin_o = p1_pos_ff;
  assign cmp1_neg_pin_o = p1_neg_ff;
  assign cmp1_irq_o = irq_ff;
endmodule : comparator_config_regs

// >>> cmp_regs_chk_assertions.sv
// checker: port-level assertions for the comparator config registers
`timescale 1ns/1ps
module cmp_regs_chk
  import cmp_regs_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic nrst_i, // reset, active low
  input wire logic clk_en_i, // run enable
  input wire cmp_regs_pkg::sfr_req_t sfr_req_i, // request
  input wire logic [7:0] sfr_rdata_o, // read data
  input wire logic cmp1_raw_i, // raw compare
  input wire cmp_regs_pkg::mux_sel_t cmp0_sel_o, // cmp0 selects
  input wire cmp_regs_pkg::mux_sel_t cmp1_sel_o, // cmp1 selects
  input wire logic [1:0] cmp1_response_mode_o, // mode
  input wire logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp0_pos_pin_o, // pins
  input wire logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp0_neg_pin_o, // pins
  input wire logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp1_pos_pin_o, // pins
  input wire logic [cmp_regs_pkg::PINS_PER_SIDE-1:0] cmp1_neg_pin_o, // pins
  input wire logic cmp1_irq_o // irq
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire w = sfr_req_i.wr && clk_en_i;
  wire r = sfr_req_i.rd && clk_en_i;
  wire [7:0] a = sfr_req_i.addr;
  AST_MODE: assert property (w && a == 8'h9E |=>
    cmp1_response_mode_o == $past(sfr_req_i.wdata[1:0])) else $error("mode not stored");
  AST_SEL0: assert property (r && a == 8'h9C |=> sfr_rdata_o == $past(cmp0_sel_o))
    else $error("cmp0 select readback");
  AST_SEL1: assert property (w && a == 8'h9F |=> cmp1_sel_o == $past(sfr_req_i.wdata))
    else $error("cmp1 select not stored");
  AST_PIN0: assert property (clk_en_i |=> cmp0_pos_pin_o == 12'h1 << $past(cmp0_sel_o.pos_sel) &&
    cmp0_neg_pin_o == 12'h1 << $past(cmp0_sel_o.neg_sel)) else $error("cmp0 pin decode");
  AST_PIN1: assert property (clk_en_i |=> cmp1_pos_pin_o == 12'h1 << $past(cmp1_sel_o.pos_sel) &&
    cmp1_neg_pin_o == 12'h1 << $past(cmp1_sel_o.neg_sel)) else $error("cmp1 pin decode");
  AST_RDMODE: assert property (r && a == 8'h9E |=> (sfr_rdata_o & 8'hCC) == 8'h00 &&
    sfr_rdata_o[1:0] == $past(cmp1_response_mode_o)) else $error("mode readback");
  // two sync flops plus the irq flop put a raw change three edges back
  AST_IRQ_RISE: assert property ($rose(cmp1_irq_o) |-> $past(cmp1_raw_i, 3) != $past(cmp1_raw_i, 4)
    || $past(sfr_req_i.wr) || $past(sfr_req_i.wr, 2)) else $error("irq without cause");
  AST_IRQ_OFF: assert property (w && a == 8'h9E && sfr_req_i.wdata[5:4] == 2'h0 ##1 !sfr_req_i.wr
    |=> !cmp1_irq_o) else $error("irq with enables off");
  cover property (r && a == 8'h9D);
  cover property ($rose(cmp1_irq_o));
  cover property (w && a == 8'h9F && sfr_req_i.wdata == 8'hFF);
endmodule : cmp_regs_chk
bind comparator_config_regs cmp_regs_chk cmp_regs_chk_inst (.mclk_i, .nrst_i, .clk_en_i, .sfr_req_i,
  .sfr_rdata_o, .cmp1_raw_i, .cmp0_sel_o, .cmp1_sel_o, .cmp1_response_mode_o, .cmp0_pos_pin_o,
  .cmp0_neg_pin_o, .cmp1_pos_pin_o, .cmp1_neg_pin_o, .cmp1_irq_o);

// >>> cmp1_core_model.sv
// partner model: comparator1 analog core behind its pin connects
`timescale 1ns/1ps
module cmp1_core_model (
  input wire logic [11:0] pos_pin_i, // + pin connects
  input wire logic [11:0] neg_pin_i, // - pin connects
  input wire logic [11:0] pos_lvl_i, // + pin levels
  input wire logic [11:0] neg_lvl_i, // - pin levels
  output logic raw_o // compare result
);
  // an unconnected input reads as ground, so it never wins
  assign raw_o = |(pos_pin_i & pos_lvl_i) & ~|(neg_pin_i & neg_lvl_i);
endmodule : cmp1_core_model

// >>> tb_top.sv
// testbench: register access, pin decode and edge flag checks
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
  import cmp_regs_pkg::*;
  logic mclk_i = 0;
  logic nrst_i = 0;
  logic raw, irq;
  sfr_req_t req = '0;
  logic [7:0] rdata, d;
  logic [11:0] p0, n0, p1, n1;
  logic [11:0] pl = '0;
  logic clk_en = 1'b1;
  logic [1:0] mode;
  mux_sel_t s1;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'hCFAC5F1E;
  always #12.5 mclk_i = ~mclk_i;
  comparator_config_regs comparator_config_regs_inst (.mclk_i, .nrst_i, .clk_en_i(clk_en), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .cmp1_raw_i(raw), .cmp0_sel_o(), .cmp1_sel_o(s1), .cmp1_response_mode_o(mode),
    .cmp0_pos_pin_o(p0), .cmp0_neg_pin_o(n0), .cmp1_pos_pin_o(p1), .cmp1_neg_pin_o(n1), .cmp1_irq_o(irq));
  cmp1_core_model cmp1_core_model_inst (.pos_pin_i(p1), .neg_pin_i(n1), .pos_lvl_i(pl),
    .neg_lvl_i(12'h000), .raw_o(raw));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [11:0] pin(input logic [3:0] c);
    return c < 4'hC ? 12'h001 << c : 12'h000;
  endfunction : pin
  // each access holds one cycle; idle() must follow before any wait
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{1'b1, 1'b0, a, v};
    @(posedge mclk_i) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i) #1;
    `CHK(rdata, e)
  endtask : rd
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(posedge mclk_i) #1;
  endtask : idle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    #1 nrst_i = 1;
    rd(8'h9C, 8'h77);
    rd(8'h9F, 8'h77);
    rd(8'h9E, 8'h02);
    rd(8'h9B, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'h9C, {4'(c), 4'(c)});
      wr(8'h9F, {~4'(c), 4'(c)});
      idle(1);
      `CHK({n0, p0}, {pin(4'(c)), pin(4'(c))})
      `CHK({n1, p1}, {pin(~4'(c)), pin(4'(c))})
      `CHK(s1, {~4'(c), 4'(c)})
    end
    for (int m = 0; m < 8; m++) begin
      d = rnd() | 8'hCC;
      d[1:0] = 2'(m);
      wr(8'h9E, d);
      rd(8'h9E, d & 8'h33);
      `CHK(mode, 2'(m))
    end
    // frozen clock enable: a write must not land
    clk_en = 1'b0;
    wr(8'h9C, 8'h00);
    clk_en = 1'b1;
    rd(8'h9C, 8'hFF);
    wr(8'h9F, 8'h10);
    wr(8'h9D, 8'h00);
    wr(8'h9E, 8'h30);
    idle(4);
    rd(8'h9D, 8'h00);
    d = rnd();
    pl = {d[3:0], rnd()} | 12'h001;
    idle(4);
    `CHK(irq, 1'b1)
    rd(8'h9D, 8'h60);
    pl = 12'h000;
    idle(4);
    rd(8'h9D, 8'h30);
    wr(8'h9D, 8'h00);
    wr(8'h9E, 8'h00);
    idle(2);
    `CHK(irq, 1'b0)
    pl = 12'h001;
    idle(4);
    `CHK(irq, 1'b0)
    wr(8'h9E, 8'h20);
    idle(2);
    `CHK(irq, 1'b1)
    wr(8'h9E, 8'h10);
    idle(2);
    `CHK(irq, 1'b0)
    pl = 12'h000;
    idle(4);
    `CHK(irq, 1'b1)
    end_sim();
  end
endmodule : tb_top
